// ---- fpll_divider_config.sv ----
// Divider and configuration logic of a fractional audio clock synthesiser.
// Assumes synchronous reference levels and a one-cycle oscillator tick input.
//
// What this block does
// - Reference is master clock or bit clock
// - Output usable only while synthesiser allowed
// - Input divider ratio is code plus one
// - Feedback integer clamps to 10..250
// - Output divider ratio is code plus one
// - Bypass divider code maps to fixed ratios
// - Fraction code adds thirty-seconds to feedback
// - Zero fraction gives pure integer division
// - Dither field selects medium, small, large, off
// - Output equals reference times N over MP
// - Clocks to 30 MHz, error shaped away
// - Bypass divides master clock for plain rates
`timescale 1ns/1ps
`default_nettype none
module fpll_divider_config (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata_reg,
	// Clock sources and oscillator
	input  wire logic       mclk_in,
	input  wire logic       bclk_in,
	input  wire logic       vco_tick,
	input  wire logic       pll_allow,
	// Divider outputs
	output var  logic       cmp_tick_reg,
	output var  logic       fb_tick_reg,
	output var  logic       pll_out_tick_reg,
	output var  logic       q_tick_reg
);

	// Every property in this block runs on the system clock, off while in reset
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// ==========================================================
	// Decoders
	function automatic logic [8:0] n_ratio(input logic [7:0] code);
		if ({1'b0, code} < fpll_pkg::N_MIN) begin
			n_ratio = fpll_pkg::N_MIN;
		end else if ({1'b0, code} > fpll_pkg::N_MAX) begin
			n_ratio = fpll_pkg::N_MAX;
		end else begin
			n_ratio = {1'b0, code};
		end
	endfunction : n_ratio

	function automatic logic [3:0] q_ratio(input logic [2:0] code);
		unique case (code)
			3'h0: q_ratio = 4'h2;
			3'h1: q_ratio = 4'h3;
			3'h2: q_ratio = 4'h4;
			3'h3: q_ratio = 4'h6;
			3'h4: q_ratio = 4'h8;
			3'h5: q_ratio = 4'ha;
			3'h6: q_ratio = 4'hc;
			3'h7: q_ratio = 4'hd;
		endcase
	endfunction : q_ratio

	// ==========================================================
	// Register file
	fpll_pkg::cfg_type cfg_reg, cfg_next;
	logic [7:0]        rdata_next;

	// Writes are masked so reserved bits hold zero
	always_comb begin
		cfg_next   = cfg_reg;
		rdata_next = reg_rdata_reg;
		if (reg_wr) begin
			unique case (reg_addr)
				fpll_pkg::ADDR_M:    cfg_next.m    = reg_wdata & fpll_pkg::MASK_M;
				fpll_pkg::ADDR_N:    cfg_next.n    = reg_wdata & fpll_pkg::MASK_N;
				fpll_pkg::ADDR_P:    cfg_next.p    = reg_wdata & fpll_pkg::MASK_P;
				fpll_pkg::ADDR_FRAC: cfg_next.frac = reg_wdata & fpll_pkg::MASK_FRAC;
				default:             cfg_next      = cfg_reg;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				fpll_pkg::ADDR_M:    rdata_next = cfg_reg.m;
				fpll_pkg::ADDR_N:    rdata_next = cfg_reg.n;
				fpll_pkg::ADDR_P:    rdata_next = cfg_reg.p;
				fpll_pkg::ADDR_FRAC: rdata_next = cfg_reg.frac;
				default:             rdata_next = 8'h00;
			endcase
		end
	end

	// Field views
	logic [5:0]           m_code;
	logic [2:0]           p_code;
	logic [2:0]           q_code;
	logic [4:0]           frac_code;
	fpll_pkg::dither_type dith;
	logic                 ref_sel;
	assign m_code    = cfg_reg.m[fpll_pkg::M_LSB +: 6];
	assign ref_sel   = cfg_reg.m[fpll_pkg::REFSEL_BIT];
	assign p_code    = cfg_reg.p[fpll_pkg::P_LSB +: 3];
	assign q_code    = cfg_reg.p[fpll_pkg::Q_LSB +: 3];
	assign frac_code = cfg_reg.frac[fpll_pkg::FRAC_LSB +: 5];
	assign dith      = fpll_pkg::dither_type'(cfg_reg.frac[fpll_pkg::DITH_LSB +: 2]);

	// ==========================================================
	// Divider state
	logic       ref_prev_reg, ref_prev_next;
	logic       mclk_prev_reg, mclk_prev_next;
	logic [5:0] m_cnt_reg, m_cnt_next;
	logic [8:0] fb_cnt_reg, fb_cnt_next;
	logic [8:0] fb_target_reg, fb_target_next;
	logic [4:0] acc_reg, acc_next;
	logic [6:0] lfsr_reg, lfsr_next;
	logic [2:0] p_cnt_reg, p_cnt_next;
	logic [3:0] q_cnt_reg, q_cnt_next;
	logic       cmp_next, fb_next, out_next, q_next;
	logic       ref_level, ref_edge, mclk_edge;
	logic [2:0] dith_amp;
	logic signed [7:0] acc_sum;

	// Reference multiplexer and edge detect
	assign ref_level = ref_sel ? bclk_in : mclk_in;
	assign ref_edge  = ref_level & ~ref_prev_reg;
	assign mclk_edge = mclk_in & ~mclk_prev_reg;

	// Dither amplitude; none when off or when the fraction is zero
	always_comb begin
		unique case (dith)
			fpll_pkg::DITH_MED:   dith_amp = 3'h2;
			fpll_pkg::DITH_SMALL: dith_amp = 3'h1;
			fpll_pkg::DITH_LARGE: dith_amp = 3'h4;
			fpll_pkg::DITH_OFF:   dith_amp = 3'h0;
		endcase
		if (frac_code == 5'h00) begin
			dith_amp = 3'h0;
		end
	end

	// Sigma-delta sum: fraction plus zero-mean dither
	assign acc_sum = $signed({3'h0, acc_reg}) + $signed({3'h0, frac_code})
		+ (lfsr_reg[0] ? $signed({5'h00, dith_amp}) : -$signed({5'h00, dith_amp}));

	// Next state of all dividers
	always_comb begin
		ref_prev_next  = ref_level;
		mclk_prev_next = mclk_in;
		m_cnt_next     = m_cnt_reg;
		fb_cnt_next    = fb_cnt_reg;
		fb_target_next = fb_target_reg;
		acc_next       = acc_reg;
		lfsr_next      = lfsr_reg;
		p_cnt_next     = p_cnt_reg;
		q_cnt_next     = q_cnt_reg;
		cmp_next       = 1'b0;
		fb_next        = 1'b0;
		out_next       = 1'b0;
		q_next         = 1'b0;
		// Input divider: code plus one reference edges
		if (ref_edge) begin
			if (m_cnt_reg >= m_code) begin
				m_cnt_next = 6'h00;
				cmp_next   = 1'b1;
			end else begin
				m_cnt_next = m_cnt_reg + 6'h01;
			end
		end
		// Feedback divider; the carry stretches one period by one tick
		if (vco_tick) begin
			if (fb_cnt_reg + 9'h001 >= fb_target_reg) begin
				fb_cnt_next = 9'h000;
				fb_next     = 1'b1;
				lfsr_next   = {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
				acc_next    = acc_sum[4:0];
				// A big fraction with large dither can carry twice in one period
				if (acc_sum >= $signed(8'(2 * fpll_pkg::FRAC_DEN))) begin
					fb_target_next = n_ratio(cfg_reg.n) + 9'h002;
				end else if (acc_sum >= $signed(8'(fpll_pkg::FRAC_DEN))) begin
					fb_target_next = n_ratio(cfg_reg.n) + 9'h001;
				end else if (acc_sum < 8'sd0) begin
					fb_target_next = n_ratio(cfg_reg.n) - 9'h001;
				end else begin
					fb_target_next = n_ratio(cfg_reg.n);
				end
			end else begin
				fb_cnt_next = fb_cnt_reg + 9'h001;
			end
			// Output divider, gated by the allow level
			if (p_cnt_reg >= p_code) begin
				p_cnt_next = 3'h0;
				out_next   = pll_allow;
			end else begin
				p_cnt_next = p_cnt_reg + 3'h1;
			end
		end
		// Bypass divider on the master clock
		if (mclk_edge) begin
			if (q_cnt_reg + 4'h1 >= q_ratio(q_code)) begin
				q_cnt_next = 4'h0;
				q_next     = 1'b1;
			end else begin
				q_cnt_next = q_cnt_reg + 4'h1;
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_reg          <= {4{fpll_pkg::RESET_VAL}};
			reg_rdata_reg    <= 8'h00;
			ref_prev_reg     <= 1'b0;
			mclk_prev_reg    <= 1'b0;
			m_cnt_reg        <= 6'h00;
			fb_cnt_reg       <= 9'h000;
			fb_target_reg    <= fpll_pkg::N_MIN;
			acc_reg          <= 5'h00;
			lfsr_reg         <= 7'h01;
			p_cnt_reg        <= 3'h0;
			q_cnt_reg        <= 4'h0;
			cmp_tick_reg     <= 1'b0;
			fb_tick_reg      <= 1'b0;
			pll_out_tick_reg <= 1'b0;
			q_tick_reg       <= 1'b0;
		end else begin
			cfg_reg          <= cfg_next;
			reg_rdata_reg    <= rdata_next;
			ref_prev_reg     <= ref_prev_next;
			mclk_prev_reg    <= mclk_prev_next;
			m_cnt_reg        <= m_cnt_next;
			fb_cnt_reg       <= fb_cnt_next;
			fb_target_reg    <= fb_target_next;
			acc_reg          <= acc_next;
			lfsr_reg         <= lfsr_next;
			p_cnt_reg        <= p_cnt_next;
			q_cnt_reg        <= q_cnt_next;
			cmp_tick_reg     <= cmp_next;
			fb_tick_reg      <= fb_next;
			pll_out_tick_reg <= out_next;
			q_tick_reg       <= q_next;
		end
	end

	// ==========================================================
	// Assertions

	a_ref_mux_edge: assert property ((ref_sel && bclk_in && !$past(bclk_in) && $past(ref_sel))
		|-> ##1 ($past(m_cnt_reg) != m_cnt_reg || $past(m_code) != m_code || m_cnt_reg == 6'h00))
		else $error("bit clock edge ignored by input divider");
	a_allow_gate: assert property (!pll_allow |=> !pll_out_tick_reg)
		else $error("output tick while synthesiser not allowed");
	a_m_wrap: assert property ((ref_edge && m_cnt_reg == m_code) |=> cmp_tick_reg && m_cnt_reg == 6'h00)
		else $error("input divider did not wrap at code plus one");
	a_n_clamp: assert property (fb_target_reg >= 9'h009 && fb_target_reg <= 9'h0fc)
		else $error("feedback ratio out of range");
	a_p_wrap: assert property ((vco_tick && p_cnt_reg == p_code && pll_allow) |=> pll_out_tick_reg)
		else $error("output divider did not wrap at code plus one");
	a_q_range: assert property ((mclk_edge && q_code == 3'h7)
		|=> q_tick_reg == ($past(q_cnt_reg) == 4'hc))
		else $error("bypass code seven did not divide by thirteen");
	a_pure_int: assert property ((frac_code == 5'h00 && acc_reg == 5'h00) |=> acc_reg == 5'h00)
		else $error("modulation with zero fraction");
	a_dither_off: assert property (dith == fpll_pkg::DITH_OFF |-> dith_amp == 3'h0)
		else $error("dither active while off");
	a_rsvd_read: assert property ((reg_rd && reg_addr == fpll_pkg::ADDR_FRAC) |=> !reg_rdata_reg[7])
		else $error("reserved bit read as one");

	c_cmp_tick: cover property (cmp_tick_reg ##[1:20] cmp_tick_reg);
	c_frac_carry: cover property (fb_tick_reg && fb_target_reg > n_ratio(cfg_reg.n));
	c_out_tick: cover property (pll_out_tick_reg);
	c_q_tick: cover property (q_tick_reg && q_code == 3'h7);

endmodule : fpll_divider_config
`default_nettype wire

// ---- fpll_pkg.sv ----
// Constants and types shared by the synthesiser divider configuration block.
// Assumes byte-wide control registers reached over an internal register port.
package fpll_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_M    = 8'h02;
	localparam logic [7:0] ADDR_N    = 8'h03;
	localparam logic [7:0] ADDR_P    = 8'h04;
	localparam logic [7:0] ADDR_FRAC = 8'h05;

	// ==========================================================
	// Writable bit masks (reserved bits stay zero)
	localparam logic [7:0] MASK_M    = 8'hfe;
	localparam logic [7:0] MASK_N    = 8'hff;
	localparam logic [7:0] MASK_P    = 8'h7e;
	localparam logic [7:0] MASK_FRAC = 8'h7f;
	localparam logic [7:0] RESET_VAL = 8'h00;

	// ==========================================================
	// Field positions
	localparam int M_LSB      = 1;
	localparam int REFSEL_BIT = 7;
	localparam int P_LSB      = 1;
	localparam int Q_LSB      = 4;
	localparam int FRAC_LSB   = 0;
	localparam int DITH_LSB   = 5;

	// ==========================================================
	// Divider limits
	localparam logic [8:0] N_MIN    = 9'h00a;
	localparam logic [8:0] N_MAX    = 9'h0fa;
	localparam int         FRAC_DEN = 32;

	// Dither levels in field order
	typedef enum logic [1:0] {
		DITH_MED,
		DITH_SMALL,
		DITH_LARGE,
		DITH_OFF
	} dither_type;

	// Stored configuration bytes
	typedef struct packed {
		logic [7:0] m;
		logic [7:0] n;
		logic [7:0] p;
		logic [7:0] frac;
	} cfg_type;

endpackage : fpll_pkg

// ---- fractional_pll_divider_config_bench.sv ----
// Self-checking bench for the synthesiser divider configuration block.
// Assumes the block's own register port and level inputs driven from here.
`timescale 1ns/1ps
`default_nettype none
module fractional_pll_divider_config_bench;
	// ==========================================================
	// Signals
	logic       clk_sys, rstn, reg_wr, reg_rd, mclk_in, bclk_in, vco_tick, pll_allow;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_reg, rv;
	logic       cmp_tick_reg, fb_tick_reg, pll_out_tick_reg, q_tick_reg;
	logic       mclk_run, bclk_run, vco_run;
	logic [31:0] c;
	int         n_mismatch, checks;
	int         q_ratio [8] = '{2, 3, 4, 6, 8, 10, 12, 13};
	int         n_code [4] = '{5, 11, 249, 255};
	int         n_div [4] = '{10, 11, 249, 250};
	logic [7:0] masks [4];

	fpll_divider_config i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_reg(reg_rdata_reg), .mclk_in(mclk_in), .bclk_in(bclk_in),
		.vco_tick(vco_tick), .pll_allow(pll_allow), .cmp_tick_reg(cmp_tick_reg),
		.fb_tick_reg(fb_tick_reg), .pll_out_tick_reg(pll_out_tick_reg),
		.q_tick_reg(q_tick_reg));

	// ==========================================================
	// Clock and source waveforms: a rising edge every two cycles
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		mclk_in  <= mclk_run & ~mclk_in;
		bclk_in  <= bclk_run & ~bclk_in;
		vco_tick <= vco_run & ~vco_tick;
	end

	// ==========================================================
	// Access and measurement tasks
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata_reg;
	endtask : rd

	function automatic logic pick(input int w);
		case (w)
			0: return cmp_tick_reg;
			1: return fb_tick_reg;
			2: return pll_out_tick_reg;
			default: return q_tick_reg;
		endcase
	endfunction : pick

	// Cycles across k periods, after two ticks let a new setting settle
	task span(input int w, input int k, output logic [31:0] cyc);
		int n;
		int t;
		n = 0;
		t = 0;
		cyc = 0;
		while (n < k + 2 && t < 20000) begin
			@(posedge clk_sys);
			#1 t++;
			if (n >= 2) cyc++;
			if (pick(w) === 1'b1) n++;
		end
	endtask : span

	// Ticks seen over a fixed number of cycles
	task cnt(input int w, input int ncyc, output logic [31:0] n);
		n = 0;
		repeat (ncyc) begin
			@(posedge clk_sys);
			#1 if (pick(w) === 1'b1) n++;
		end
	endtask : cnt

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task stop_test;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// ==========================================================
	// Watchdog well beyond the expected run length
	initial begin
		#300000;
		n_mismatch++;
		stop_test();
	end

	// ==========================================================
	// Test sequence
	initial begin
		{rstn, reg_wr, reg_rd, pll_allow} = '0;
		{mclk_run, bclk_run, vco_run} = '0;
		{reg_addr, reg_wdata} = '0;
		masks = '{fpll_pkg::MASK_M, fpll_pkg::MASK_N, fpll_pkg::MASK_P, fpll_pkg::MASK_FRAC};
		n_mismatch = 0;
		checks = 0;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		// Reset values, reserved bits and an unmapped address
		for (int i = 0; i < 4; i++) begin
			rd(8'h02 + 8'(i), rv);
			check(32'(rv), 32'(fpll_pkg::RESET_VAL));
			wr(8'h02 + 8'(i), 8'hff);
			rd(8'h02 + 8'(i), rv);
			check(32'(rv), 32'(masks[i]));
		end
		wr(8'h06, 8'hff);
		rd(8'h06, rv);
		check(32'(rv), 32'h0);
		$display("test registers done");
		// Input divider on master clock, then on bit clock
		mclk_run <= 1'b1;
		for (int m = 0; m < 64; m += 21) begin
			wr(fpll_pkg::ADDR_M, 8'(m << 1));
			span(0, 4, c);
			check(c, 32'(8 * (m + 1)));
		end
		wr(fpll_pkg::ADDR_M, 8'h82);
		mclk_run <= 1'b0;
		bclk_run <= 1'b1;
		span(0, 2, c);
		check(c, 32'h8);
		bclk_run <= 1'b0;
		mclk_run <= 1'b1;
		cnt(0, 40, c);
		check(c, 32'h0);
		$display("test input divider done");
		// Bypass divider map
		for (int q = 0; q < 8; q++) begin
			wr(fpll_pkg::ADDR_P, 8'(q << 4));
			span(3, 2, c);
			check(c, 32'(4 * q_ratio[q]));
		end
		$display("test bypass divider done");
		// Output divider and its allow gate, the allow level moved on a clock edge
		@(posedge clk_sys);
		vco_run   <= 1'b1;
		pll_allow <= 1'b1;
		for (int p = 0; p < 8; p += 7) begin
			wr(fpll_pkg::ADDR_P, 8'(p << 1));
			span(2, 2, c);
			check(c, 32'(4 * (p + 1)));
		end
		@(posedge clk_sys);
		pll_allow <= 1'b0;
		cnt(2, 64, c);
		check(c, 32'h0);
		$display("test output divider done");
		// Feedback integer clamp with dither off and no fraction
		wr(fpll_pkg::ADDR_FRAC, 8'h60);
		for (int i = 0; i < 4; i++) begin
			wr(fpll_pkg::ADDR_N, 8'(n_code[i]));
			span(1, 2, c);
			check(c, 32'(4 * n_div[i]));
		end
		// Zero fraction stays integer under every dither level
		wr(fpll_pkg::ADDR_N, 8'h14);
		for (int d = 0; d < 4; d++) begin
			wr(fpll_pkg::ADDR_FRAC, 8'(d << 5));
			span(1, 4, c);
			check(c, 32'd160);
		end
		// Fraction of five thirty-seconds over a full accumulator cycle
		wr(fpll_pkg::ADDR_N, 8'h0a);
		wr(fpll_pkg::ADDR_FRAC, 8'h65);
		span(1, 32, c);
		check(c, 32'(2 * (32 * 10 + 5)));
		// Small dither on the same fraction shifts the carries by at most one
		wr(fpll_pkg::ADDR_FRAC, 8'h25);
		span(1, 32, c);
		check(32'(c >= 32'd648 && c <= 32'd652), 32'h1);
		$display("test feedback divider done");
		// Mid-run reset returns the fraction register to its reset value
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(fpll_pkg::ADDR_FRAC, rv);
		check(32'(rv), 32'(fpll_pkg::RESET_VAL));
		$display("test mid-run reset done");
		stop_test();
	end
endmodule : fractional_pll_divider_config_bench
`default_nettype wire
